// >>> rtl/audio_slot_buffer_control.v
// Slot-driven buffer sequencing, status flags and serial shifter of the converter serial port
//
// The APB register port and the address map were decided locally.
`include "audio_slot_map.vh"
`default_nettype none

module audio_slot_buffer_control (
    // System
    input  wire        clk_sys_in,
    input  wire        rst_in,
    // APB slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output wire        pready_out,
    output wire        pslverr_out,
    output wire [31:0] prdata_out,
    // Serial link
    input  wire        serial_bit_clock_in,
    input  wire        serial_data_in_in,
    output wire        serial_data_out_out,
    output wire        serial_data_out_oe_n_out,
    output wire        frame_sync_pin_out,
    // Events
    output wire        data_irq_out,
    output wire        error_irq_out,
    output wire        dma_request_out
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_RUN   = 2'h2;

    // Software registers
    reg  [15:0] ctrl_one_r;
    reg  [15:0] ctrl_two_r;
    reg  [15:0] tx_slot_en_r;
    reg  [15:0] rx_slot_en_r;
    reg  [15:0] tx_hold_r [0:3];
    reg  [15:0] rx_hold_r [0:3];
    reg  [3:0]  tx_written_r;
    reg  [3:0]  underrun_loc_r;
    reg  [3:0]  rx_unread_r;
    reg  [3:0]  overrun_loc_r;
    reg         tx_empty_r;
    reg  [31:0] prdata_r;
    reg         data_irq_r;
    reg         error_irq_r;
    reg         dma_req_r;

    // Link side state
    reg  [15:0] tx_buf_r [0:3];
    reg  [15:0] rx_buf_r [0:3];
    reg  [1:0]  state_r;
    reg  [1:0]  start_cnt_r;
    reg  [3:0]  bit_r;
    reg  [3:0]  slot_r;
    reg  [1:0]  ptr_r;
    reg         pre_r;
    reg  [15:0] tx_sh_r;
    reg  [15:0] rx_sh_r;
    reg         tx_act_r;
    reg         fs_r;
    reg         sck_s1_r;
    reg         sck_s2_r;
    reg         sck_s3_r;
    reg         sdi_s1_r;
    reg         sdi_s2_r;

    integer     i;

    // Decoded fields
    wire        enable_w   = ctrl_one_r[`C1_ENABLE];
    wire        loop_w     = ctrl_one_r[`C1_LOOPBACK];
    wire        fill_w     = ctrl_one_r[`C1_UNDERRUN_FILL];
    wire        idle_md_w  = ctrl_one_r[`C1_IDLE_MODE];
    wire        justify_w  = ctrl_one_r[`C1_JUSTIFY];
    wire [1:0]  blen_w     = ctrl_two_r[`C2_BLEN_HI:`C2_BLEN_LO];
    wire [3:0]  flen_w     = ctrl_two_r[`C2_FLEN_HI:`C2_FLEN_LO];
    wire [3:0]  ws_w       = ctrl_two_r[`C2_WS_HI:`C2_WS_LO];
    wire [3:0]  inuse_w    = (blen_w == 2'h0) ? 4'h1 : (blen_w == 2'h1) ? 4'h3 :
                             (blen_w == 2'h2) ? 4'h7 : 4'hF;

    // Bit clock edges, seen only after the two-stage synchroniser
    wire        rise_w     = sck_s2_r & ~sck_s3_r;
    wire        fall_w     = ~sck_s2_r & sck_s3_r;
    wire        sdo_w      = tx_act_r & tx_sh_r[15];
    wire        sdi_w      = loop_w ? sdo_w : sdi_s2_r;
    wire        slot_tx_w  = tx_slot_en_r[slot_r];
    wire        slot_rx_w  = rx_slot_en_r[slot_r];
    wire        slot_end_w = (state_r == ST_RUN) && fall_w && (bit_r == ws_w) && !pre_r;
    wire        advance_w  = slot_end_w && (slot_tx_w || slot_rx_w);
    wire        xfer_w     = (advance_w && (ptr_r == blen_w)) ||
                             ((state_r == ST_START) && rise_w && (start_cnt_r == `START_EDGES - 2'h1));

    // Position of the next bit on a rising edge
    wire        last_bit_w  = (bit_r == ws_w);
    wire        last_slot_w = (slot_r == flen_w);
    wire [3:0]  nbit_w      = last_bit_w ? 4'h0 : bit_r + 4'h1;
    wire [3:0]  nslot_w     = last_bit_w ? (last_slot_w ? 4'h0 : slot_r + 4'h1) : slot_r;
    wire        ntx_en_w    = tx_slot_en_r[nslot_w];

    // Left justification of the received word
    wire [3:0]  rx_shift_w  = 4'hF - ws_w;
    // Word completed at this slot end, including the bit sampled right now
    wire [15:0] rx_word_w   = {rx_sh_r[14:0], sdi_w} << rx_shift_w;

    // APB decode
    wire        apb_acc_w  = psel_in & penable_in;
    wire        apb_setup_w = psel_in & ~penable_in;
    wire        is_tx_w    = (paddr_in[11:4] == `OFS_TX_HOLD_BASE >> 4) && (paddr_in[1:0] == 2'h0);
    wire        is_rx_w    = (paddr_in[11:4] == `OFS_RX_HOLD_BASE >> 4) && (paddr_in[1:0] == 2'h0);
    wire [1:0]  loc_w      = paddr_in[3:2];
    wire        mapped_w   = is_tx_w || is_rx_w || (paddr_in == `OFS_CTRL_ONE) ||
                             (paddr_in == `OFS_CTRL_TWO) || (paddr_in == `OFS_STATUS) ||
                             (paddr_in == `OFS_TX_SLOT_EN) || (paddr_in == `OFS_RX_SLOT_EN);
    wire        wr_w       = apb_acc_w & pwrite_in & mapped_w;
    wire        rd_w       = apb_acc_w & ~pwrite_in & mapped_w;
    wire [3:0]  rx_rd_w    = (rd_w && is_rx_w) ? (4'h1 << loc_w) : 4'h0;
    wire [3:0]  tx_wr_w    = (wr_w && is_tx_w) ? (4'h1 << loc_w) : 4'h0;

    // Flags are combinations of per-location state restricted to in-use entries
    wire        rx_full_w  = |(rx_unread_r & inuse_w);
    wire        rx_ovr_w   = |(overrun_loc_r & inuse_w);
    wire        tx_unf_w   = |(underrun_loc_r & inuse_w);
    wire [3:0]  unf_new_w  = inuse_w & ~tx_written_r;
    wire [3:0]  ovr_new_w  = inuse_w & rx_unread_r;

    // Status word is built only from hardware state, so writes cannot reach it
    wire [15:0] status_w   = {4'h0, slot_r, 4'h0, rx_ovr_w, rx_full_w, tx_unf_w, tx_empty_r};

    assign pready_out  = 1'b1;
    assign pslverr_out = apb_acc_w & ~mapped_w;
    assign prdata_out  = prdata_r;
    assign serial_data_out_out      = sdo_w;
    assign serial_data_out_oe_n_out = ~tx_act_r & idle_md_w;
    assign frame_sync_pin_out       = fs_r;
    assign data_irq_out    = data_irq_r;
    assign error_irq_out   = error_irq_r;
    assign dma_request_out = dma_req_r;

    // Synchronisers for the bit clock and data pins
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= serial_bit_clock_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            sdi_s1_r <= serial_data_in_in;
            sdi_s2_r <= sdi_s1_r;
        end
    end

    // Frame and slot sequencer, shifters and the hidden buffer memory
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_r     <= ST_IDLE;
            start_cnt_r <= 2'h0;
            bit_r       <= 4'h0;
            slot_r      <= 4'h0;
            ptr_r       <= 2'h0;
            pre_r       <= 1'b0;
            tx_sh_r     <= 16'h0000;
            rx_sh_r     <= 16'h0000;
            tx_act_r    <= 1'b0;
            fs_r        <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                tx_buf_r[i] <= 16'h0000;
                rx_buf_r[i] <= 16'h0000;
            end
        end else begin
            // Buffer transfer: pending holding words become the next words to send
            if (xfer_w) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (inuse_w[i]) begin
                        if (tx_written_r[i] || fill_w) begin
                            tx_buf_r[i] <= tx_hold_r[i];
                        end else begin
                            tx_buf_r[i] <= 16'h0000;
                        end
                    end
                end
            end
            case (state_r)
                ST_IDLE: begin
                    tx_act_r <= 1'b0;
                    fs_r     <= 1'b0;
                    if (enable_w) begin
                        state_r     <= ST_START;
                        start_cnt_r <= 2'h0;
                    end
                end
                ST_START: begin
                    if (!enable_w) begin
                        state_r <= ST_IDLE;
                    end else if (rise_w) begin
                        start_cnt_r <= start_cnt_r + 2'h1;
                        if (xfer_w) begin
                            state_r <= ST_RUN;
                            ptr_r   <= 2'h0;
                            // One dummy bit lets the early frame sync lead slot 0
                            pre_r   <= 1'b1;
                            bit_r   <= ws_w;
                            slot_r  <= flen_w;
                            fs_r    <= ~justify_w;
                        end
                    end
                end
                ST_RUN: begin
                    if (rise_w) begin
                        pre_r  <= 1'b0;
                        bit_r  <= nbit_w;
                        slot_r <= nslot_w;
                        // Frame sync leads slot 0 by one bit, or coincides with it
                        if (justify_w) begin
                            fs_r <= (nslot_w == 4'h0) && (nbit_w == 4'h0);
                        end else begin
                            fs_r <= (nslot_w == flen_w) && (nbit_w == ws_w);
                        end
                        if (nbit_w == 4'h0) begin
                            tx_act_r <= ntx_en_w;
                            tx_sh_r  <= ntx_en_w ? tx_buf_r[ptr_r] : 16'h0000;
                        end else begin
                            tx_sh_r <= {tx_sh_r[14:0], 1'b0};
                        end
                    end
                    if (fall_w && !pre_r) begin
                        rx_sh_r <= {rx_sh_r[14:0], sdi_w};
                    end
                    // End of slot: store received word and step the shared pointer
                    if (slot_end_w) begin
                        if (slot_rx_w) begin
                            rx_buf_r[ptr_r] <= rx_word_w;
                        end
                        if (advance_w) begin
                            ptr_r <= (ptr_r == blen_w) ? 2'h0 : ptr_r + 2'h1;
                        end
                        // Disable takes effect only at the end of a whole frame
                        if (last_slot_w && !enable_w) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Software registers, per-location flags and event pulses
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_one_r     <= `CTRL_ONE_RST;
            ctrl_two_r     <= `CTRL_TWO_RST;
            tx_slot_en_r   <= `SLOT_EN_RST;
            rx_slot_en_r   <= `SLOT_EN_RST;
            tx_written_r   <= 4'h0;
            underrun_loc_r <= 4'h0;
            rx_unread_r    <= 4'h0;
            overrun_loc_r  <= 4'h0;
            tx_empty_r     <= 1'b0;
            prdata_r       <= 32'h00000000;
            data_irq_r     <= 1'b0;
            error_irq_r    <= 1'b0;
            dma_req_r      <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                tx_hold_r[i] <= 16'h0000;
                rx_hold_r[i] <= 16'h0000;
            end
        end else begin
            // Read data is latched in the setup phase so the access phase needs no wait
            if (apb_setup_w) begin
                prdata_r <= 32'h00000000;
                if (paddr_in == `OFS_CTRL_ONE) prdata_r <= {16'h0000, ctrl_one_r};
                if (paddr_in == `OFS_CTRL_TWO) prdata_r <= {16'h0000, ctrl_two_r};
                if (paddr_in == `OFS_STATUS) prdata_r <= {16'h0000, status_w};
                if (paddr_in == `OFS_TX_SLOT_EN) prdata_r <= {16'h0000, tx_slot_en_r};
                if (paddr_in == `OFS_RX_SLOT_EN) prdata_r <= {16'h0000, rx_slot_en_r};
                if (is_rx_w) prdata_r <= {16'h0000, rx_hold_r[loc_w]};
            end
            if (wr_w) begin
                if (paddr_in == `OFS_CTRL_ONE) ctrl_one_r <= pwdata_in[15:0] & `C1_WR_MASK;
                if (paddr_in == `OFS_CTRL_TWO) ctrl_two_r <= pwdata_in[15:0] & `C2_WR_MASK;
                if (paddr_in == `OFS_TX_SLOT_EN) tx_slot_en_r <= pwdata_in[15:0];
                if (paddr_in == `OFS_RX_SLOT_EN) rx_slot_en_r <= pwdata_in[15:0];
                if (is_tx_w) tx_hold_r[loc_w] <= pwdata_in[15:0];
            end
            // Receive words land in the holding registers at each transfer; the word that
            // closes the buffer bypasses the buffer memory, else it would lag one transfer
            if (xfer_w) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (inuse_w[i]) begin
                        if (advance_w && slot_rx_w && (ptr_r == i)) begin
                            rx_hold_r[i] <= rx_word_w;
                        end else begin
                            rx_hold_r[i] <= rx_buf_r[i];
                        end
                    end
                end
            end
            // Per-location flags: a transfer event wins over a clearing access
            tx_written_r   <= xfer_w ? 4'h0 : (tx_written_r | tx_wr_w);
            underrun_loc_r <= (underrun_loc_r & ~tx_wr_w) | (xfer_w ? unf_new_w : 4'h0);
            rx_unread_r    <= (rx_unread_r & ~rx_rd_w) | (xfer_w ? inuse_w : 4'h0);
            overrun_loc_r  <= (overrun_loc_r & ~rx_rd_w) | (xfer_w ? ovr_new_w : 4'h0);
            if (xfer_w) begin
                tx_empty_r <= 1'b1;
            end else if (|(tx_wr_w & inuse_w)) begin
                tx_empty_r <= 1'b0;
            end
            data_irq_r  <= xfer_w;
            dma_req_r   <= xfer_w && (blen_w == 2'h0);
            error_irq_r <= xfer_w && ctrl_one_r[`C1_ERR_IRQ_EN] && (|(unf_new_w | ovr_new_w));
        end
    end

endmodule

`default_nettype wire

// >>> rtl/audio_slot_map.vh
// Register map, field positions and sequencing constants of the slot buffer block
`ifndef AUDIO_SLOT_MAP_VH
`define AUDIO_SLOT_MAP_VH

// APB byte offsets
`define OFS_CTRL_ONE        12'h000
`define OFS_CTRL_TWO        12'h004
`define OFS_STATUS          12'h008
`define OFS_TX_SLOT_EN      12'h00C
`define OFS_RX_SLOT_EN      12'h010
`define OFS_TX_HOLD_BASE    12'h020
`define OFS_RX_HOLD_BASE    12'h030

// control_reg_one fields
`define C1_ENABLE           15
`define C1_LOOPBACK         11
`define C1_UNDERRUN_FILL    7
`define C1_IDLE_MODE        6
`define C1_JUSTIFY          5
`define C1_ERR_IRQ_EN       0
`define C1_WR_MASK          16'h88E1

// control_reg_two fields
`define C2_BLEN_HI          11
`define C2_BLEN_LO          10
`define C2_FLEN_HI          7
`define C2_FLEN_LO          4
`define C2_WS_HI            3
`define C2_WS_LO            0
`define C2_WR_MASK          16'h0CFF

// serial_interface_status fields
`define ST_TX_EMPTY         0
`define ST_TX_UNDERRUN      1
`define ST_RX_FULL          2
`define ST_RX_OVERRUN       3
`define ST_SLOT_LO          8

// Reset values
`define CTRL_ONE_RST        16'h0000
`define CTRL_TWO_RST        16'h000F
`define SLOT_EN_RST         16'h0000

// Bit clock rising edges from enable to the first buffer transfer
`define START_EDGES         2'h3

`endif

// >>> verification/audio_slot_buffer_control_chk.sv
// Concurrent checks on the ports of the slot buffer control block
`include "audio_slot_map.vh"
`default_nettype none
module audio_slot_chk (
    // System
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    // APB
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [31:0] prdata_out,
    // Serial link
    input wire logic        serial_bit_clock_in,
    input wire logic        serial_data_in_in,
    input wire logic        serial_data_out_out,
    input wire logic        serial_data_out_oe_n_out,
    input wire logic        frame_sync_pin_out,
    // Events
    input wire logic        data_irq_out,
    input wire logic        error_irq_out,
    input wire logic        dma_request_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] c1_r;
    logic [15:0] c2_r;
    wire logic   mapped;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // Shadow of the control words, seen only through completed APB writes
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            c1_r <= `CTRL_ONE_RST;
            c2_r <= `CTRL_TWO_RST;
        end else if (psel_in && penable_in && pwrite_in) begin
            if (paddr_in == `OFS_CTRL_ONE) c1_r <= pwdata_in[15:0] & `C1_WR_MASK;
            if (paddr_in == `OFS_CTRL_TWO) c2_r <= pwdata_in[15:0] & `C2_WR_MASK;
        end
    end

    // Decoded word addresses of the register map
    assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= `OFS_RX_SLOT_EN || paddr_in[11:5] == 7'h01);

    chk_dma_with_irq: assert property (dma_request_out |-> data_irq_out)
        else $error("dma request without buffer transfer");
    chk_dma_len_zero: assert property (data_irq_out && c2_r[11:10] == 2'h0 |-> dma_request_out)
        else $error("no dma request at transfer with length zero");
    chk_err_at_xfer: assert property (error_irq_out |-> data_irq_out)
        else $error("error interrupt outside a buffer transfer");
    chk_err_enable: assert property (error_irq_out |-> c1_r[`C1_ERR_IRQ_EN])
        else $error("error interrupt while disabled");
    chk_irq_pulse: assert property (data_irq_out |=> !data_irq_out [*2])
        else $error("data interrupt not a single pulse");
    chk_first_irq: assert property ($rose(c1_r[`C1_ENABLE]) |-> ##[1:48] data_irq_out)
        else $error("no start-up interrupt after enable");
    chk_idle_drive: assert property (!c1_r[`C1_IDLE_MODE] |-> !serial_data_out_oe_n_out)
        else $error("output released with idle mode clear");
    chk_fs_enabled: assert property ($rose(frame_sync_pin_out) |-> c1_r[`C1_ENABLE])
        else $error("frame sync while disabled");
    chk_unmapped_err: assert property (psel_in && penable_in && !mapped |-> pslverr_out && pready_out)
        else $error("unmapped access not refused");

    // Main scenarios reached
    cover property (error_irq_out);
    cover property (dma_request_out);
    cover property (pslverr_out);
    cover property ($rose(frame_sync_pin_out));
endmodule
`default_nettype wire

// >>> verification/codec_model.sv
// Codec model: free-running bit clock master with a busy data line
`default_nettype none
module codec_model (
    // Link
    output logic            bit_clock_out,
    output logic            data_out,
    input wire logic        frame_sync_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // 800 ns bit clock, phase unrelated to the system clock; data changes every bit except while frame sync is high
    // so that a wrongly selected input can never look like the looped-back word
    initial begin
        bit_clock_out = 1'b0;
        data_out = 1'b1;
        #137;
        forever begin
            #400 bit_clock_out = ~bit_clock_out;
            if (!bit_clock_out) data_out = ~data_out ^ frame_sync_in;
        end
    end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench: APB master, loopback traffic and status flag checks
`include "audio_slot_map.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        clk_sys_in;
    logic        rst_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in;
    wire logic   pready_out;
    wire logic   pslverr_out;
    wire logic [31:0] prdata_out;
    wire logic   bclk;
    wire logic   sdi;
    wire logic   sdo;
    wire logic   oe_n;
    wire logic   fs;
    wire logic   data_irq_out;
    wire logic   eirq;
    wire logic   dreq;
    logic [64:0] q[$];
    logic [64:0] e;
    logic [31:0] lfsr;
    logic [15:0] hist[0:7];
    int          fails;
    int          cmp_count;

    audio_slot_buffer_control dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
        .serial_bit_clock_in(bclk), .serial_data_in_in(sdi), .serial_data_out_out(sdo),
        .serial_data_out_oe_n_out(oe_n), .frame_sync_pin_out(fs), .data_irq_out(data_irq_out),
        .error_irq_out(eirq), .dma_request_out(dreq));
    codec_model codec (.bit_clock_out(bclk), .data_out(sdi), .frame_sync_in(fs));

    // 10 MHz system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // Random words from a 32-bit shift register
    function logic [15:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
        return lfsr[15:0];
    endfunction

    // One APB transfer; a read notes its masked expectation for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic err);
        if (!wr) q.push_back({err, m, d & m});
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        while (pready_out !== 1'b1) @(posedge clk_sys_in);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // Wait for a buffer transfer and let its updates settle
    task wirq();
        @(posedge clk_sys_in);
        while (data_irq_out !== 1'b1) @(posedge clk_sys_in);
        repeat (2) @(posedge clk_sys_in);
    endtask

    // Read monitor: compares each completed read with the oldest note
    always @(posedge clk_sys_in) begin
        if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
            e = q.pop_front();
            cmp_count++;
            if ({pslverr_out, prdata_out & e[63:32]} !== {e[64], e[31:0]}) begin
                fails++;
                $display("wrong value at %0t: got %h expected %h", $time, {pslverr_out, prdata_out}, e[64:0]);
            end
        end
    end

    task results();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog: the run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fails++;
        results();
    end

    // Main sequence
    initial begin
        lfsr = 32'hA3533ECC;
        fails = 0;
        cmp_count = 0;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        rst_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        apb(0, `OFS_CTRL_ONE, {16'h0000, `CTRL_ONE_RST}, ALL, 0);
        apb(0, `OFS_CTRL_TWO, {16'h0000, `CTRL_TWO_RST}, ALL, 0);
        apb(0, `OFS_TX_SLOT_EN, 32'h0, ALL, 0);
        apb(0, `OFS_RX_SLOT_EN, 32'h0, ALL, 0);
        apb(0, `OFS_TX_HOLD_BASE, 32'h0, ALL, 0);
        apb(1, `OFS_STATUS, ALL, 32'h0, 0);
        apb(0, `OFS_STATUS, 32'h0, 32'h00000F0E, 0);
        apb(0, 12'h014, 32'h0, ALL, 1);
        // One 8-bit slot per frame, length zero, slot 0 both ways, looped back
        apb(1, `OFS_CTRL_TWO, 32'h00000007, 32'h0, 0);
        apb(1, `OFS_TX_SLOT_EN, 32'h00000001, 32'h0, 0);
        apb(1, `OFS_RX_SLOT_EN, 32'h00000001, 32'h0, 0);
        hist[0] = rnd();
        apb(1, `OFS_TX_HOLD_BASE, {16'h0000, hist[0]}, 32'h0, 0);
        apb(1, `OFS_CTRL_ONE, 32'h00008881, 32'h0, 0);
        // Word written after transfer k returns through the loop at transfer k+2
        for (int k = 0; k < 5; k++) begin
            wirq();
            apb(0, `OFS_RX_HOLD_BASE, (k > 0) ? {16'h0000, hist[k - 1] & 16'hFF00} : 32'h0, ALL, 0);
            hist[k + 1] = rnd();
            apb(1, `OFS_TX_HOLD_BASE, {16'h0000, hist[k + 1]}, 32'h0, 0);
            apb(0, `OFS_STATUS, 32'h0, 32'h00000F0F, 0);
        end
        // Leave one transfer unserviced: unread receive word and unwritten transmit word
        wirq();
        wirq();
        apb(0, `OFS_STATUS, 32'h0000000A, 32'h0000000A, 0);
        apb(0, `OFS_RX_HOLD_BASE, {16'h0000, hist[5] & 16'hFF00}, ALL, 0);
        wirq();
        apb(0, `OFS_RX_HOLD_BASE, {16'h0000, hist[5] & 16'hFF00}, ALL, 0);
        apb(1, `OFS_TX_HOLD_BASE, {16'h0000, rnd()}, 32'h0, 0);
        apb(0, `OFS_STATUS, 32'h0, 32'h00000002, 0);
        repeat (4) @(posedge clk_sys_in);
        results();
    end
endmodule

bind audio_slot_buffer_control audio_slot_chk chk_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .serial_bit_clock_in(serial_bit_clock_in), .serial_data_in_in(serial_data_in_in),
    .serial_data_out_out(serial_data_out_out), .serial_data_out_oe_n_out(serial_data_out_oe_n_out),
    .frame_sync_pin_out(frame_sync_pin_out), .data_irq_out(data_irq_out), .error_irq_out(error_irq_out),
    .dma_request_out(dma_request_out));
`default_nettype wire
